// ===== hdl/occ_cfg.svh
// Operation
// - channel on bits 4..0 switch their channel on when 1, off when 0; read/write.
// - combine select 0: drive is input pin OR channel on bit.
// - combine select 1: drive is input pin AND channel on bit.
// - config bits 2..0 pick bulb (0) or LED (1) mode for channels 2..0.
// - thermal shutdown turns channel off and sets a latch holding it off.
// - over-temperature latch stays set while the logic supply is absent; here rst_n clears it like every other register.
// - relatch release needs cooled sensor and host write of clear thermal latch.
// - one clear thermal latch write clears the latch of every cooled channel at once.
// - dynamic temperature detector turns its channel off on sudden rise.
// - fault flag is set while channel is held off by dynamic shutdown.
// - reading a channel's fault flag clears it.
// - flag sets again if dynamic shutdown persists after the clearing read.
// - on loss of ground every channel goes or stays off.
// - inverse current into an output clears that channel's fault flag.
`ifndef OCC_CFG_SVH
`define OCC_CFG_SVH
`define OCC_NCH        5
`define OCC_NLED       3
`define OCC_SW_W       6
`define OCC_CFG_W      4
`define OCC_CFG_COMB   3
`define OCC_SW_RST     6'h00
`define OCC_CFG_RST    4'h0
`define OCC_UNDEF_BIT  1'b0
`endif

// ===== hdl/occ_pkg.sv
package occ_pkg;
  // register bank contents
  typedef struct packed {
    logic       spare;
    logic [4:0] on;
  } occ_switch_s;
  typedef struct packed {
    logic       comb_and;
    logic [2:0] led;
  } occ_config_s;
  // per-channel sensor inputs
  typedef struct packed {
    logic [4:0] over_temp;
    logic [4:0] cooled;
    logic [4:0] dyn_shut;
    logic [4:0] inverse;
  } occ_sense_s;
endpackage

// ===== hdl/occ_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "occ_cfg.svh"
module occ_top import occ_pkg::*; (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // register access from frame logic
  input  wire logic                   sw_wr,
  input  wire logic [`OCC_SW_W-1:0]   sw_wdata,
  input  wire logic                   cfg_wr,
  input  wire logic [`OCC_CFG_W-1:0]  cfg_wdata,
  input  wire logic                   hw_ctrl_wr,
  input  wire logic                   clear_thermal_latch,
  input  wire logic                   fault_rd,
  // pins and sensors, asynchronous
  input  wire logic [`OCC_NCH-1:0]    channel_input_pin,
  input  wire occ_sense_s             sense,
  input  wire logic                   gnd_ok,
  // register readback
  output logic [`OCC_SW_W-1:0]        sw_rdata,
  output logic [`OCC_CFG_W-1:0]       cfg_rdata,
  output logic [`OCC_NCH-1:0]         fault_flag,
  output logic [`OCC_NCH-1:0]         ot_latch,
  // power stage
  output logic [`OCC_NCH-1:0]         stage_on,
  output logic [`OCC_NLED-1:0]        lamp_diode_mode_bit,
  output logic                        spare_bias
);
  occ_switch_s sw_q;
  occ_config_s cfg_q;
  logic [`OCC_NCH-1:0] ot_q;
  logic [`OCC_NCH-1:0] flag_q;
  logic [`OCC_NCH-1:0] stage_q;
  logic [`OCC_NCH-1:0] pin_s1_q, pin_s2_q;
  occ_sense_s          sns_s1_q, sns_s2_q;
  logic                gnd_s1_q, gnd_s2_q;
  logic [`OCC_NCH-1:0] comb_d;
  logic [`OCC_NCH-1:0] stage_d;

  // two-stage synchronisers for pins and sensors
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      sns_s1_q <= '0;
      sns_s2_q <= '0;
      gnd_s1_q <= 1'b0;
      gnd_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= channel_input_pin;
      pin_s2_q <= pin_s1_q;
      sns_s1_q <= sense;
      sns_s2_q <= sns_s1_q;
      gnd_s1_q <= gnd_ok;
      gnd_s2_q <= gnd_s1_q;
    end
  end

  // channel switch register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_q <= `OCC_SW_RST;
    end else if (sw_wr) begin
      sw_q <= sw_wdata;
    end
  end

  // combine and lamp mode config register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= `OCC_CFG_RST;
    end else if (cfg_wr) begin
      cfg_q <= cfg_wdata;
    end
  end

  // over-temperature latches; set beats clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ot_q <= '0; // latch state is cleared by rst_n, the same reset as every other register
    end else begin
      for (int i = 0; i < `OCC_NCH; i++) begin
        if (sns_s2_q.over_temp[i]) begin
          ot_q[i] <= 1'b1;
        end else if (hw_ctrl_wr && clear_thermal_latch && sns_s2_q.cooled[i]) begin
          ot_q[i] <= 1'b0;
        end
      end
    end
  end

  // fault flags: dynamic shutdown sets, read or inverse current clears
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= '0;
    end else begin
      for (int i = 0; i < `OCC_NCH; i++) begin
        if (sns_s2_q.dyn_shut[i]) begin
          flag_q[i] <= 1'b1;
        end else if (fault_rd || sns_s2_q.inverse[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // combine and gate per channel
  always_comb begin
    for (int i = 0; i < `OCC_NCH; i++) begin
      comb_d[i] = cfg_q.comb_and ? (pin_s2_q[i] & sw_q.on[i])
                                 : (pin_s2_q[i] | sw_q.on[i]);
      stage_d[i] = comb_d[i] & ~ot_q[i] & ~sns_s2_q.over_temp[i]
                   & ~sns_s2_q.dyn_shut[i] & gnd_s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage_q <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

  // outputs from flip-flops, except sw_rdata bit 5, which is a constant 0
  always_comb begin
    sw_rdata            = {`OCC_UNDEF_BIT, sw_q.on};
    cfg_rdata           = cfg_q;
    fault_flag          = flag_q;
    ot_latch            = ot_q;
    stage_on            = stage_q;
    lamp_diode_mode_bit = cfg_q.led;
    spare_bias          = sw_q.spare;
  end

  // register write checks
  property p_sw_write;
    @(posedge clk) disable iff (!rst_n)
      sw_wr |=> (sw_q.on == $past(sw_wdata[`OCC_NCH-1:0]));
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("switch write fail");
  property p_cfg_write;
    @(posedge clk) disable iff (!rst_n)
      cfg_wr |=> ((cfg_q.led == $past(cfg_wdata[`OCC_NLED-1:0]))
                  && (cfg_q.comb_and == $past(cfg_wdata[`OCC_CFG_COMB])));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write fail");

  // combine checks
  property p_or_mode;
    @(posedge clk) disable iff (!rst_n)
      (!cfg_q.comb_and && sw_q.on[2] && !ot_q[2] && gnd_s2_q && !sns_s2_q.dyn_shut[2]
       && !sns_s2_q.over_temp[2]) |=> stage_q[2];
  endproperty
  a_or_mode: assert property (p_or_mode) else $error("or mode fail");
  property p_and_mode;
    @(posedge clk) disable iff (!rst_n)
      (cfg_q.comb_and && !pin_s2_q[3]) |=> !stage_q[3];
  endproperty
  a_and_mode: assert property (p_and_mode) else $error("and mode fail");

  // thermal latch checks
  property p_ot_set;
    @(posedge clk) disable iff (!rst_n)
      (sns_s2_q.over_temp != '0)
        |=> ((ot_q & $past(sns_s2_q.over_temp)) == $past(sns_s2_q.over_temp));
  endproperty
  a_ot_set: assert property (p_ot_set) else $error("latch not set");
  property p_ot_holds_off;
    @(posedge clk) disable iff (!rst_n)
      (ot_q != '0) |=> ((stage_q & $past(ot_q)) == '0);
  endproperty
  a_ot_holds_off: assert property (p_ot_holds_off) else $error("latched channel on");
  property p_ot_refuse;
    @(posedge clk) disable iff (!rst_n)
      ((ot_q & ~sns_s2_q.cooled) != '0)
        |=> ((ot_q & $past(ot_q) & ~$past(sns_s2_q.cooled))
             == ($past(ot_q) & ~$past(sns_s2_q.cooled)));
  endproperty
  a_ot_refuse: assert property (p_ot_refuse) else $error("hot latch released");
  property p_ot_clear;
    @(posedge clk) disable iff (!rst_n)
      (ot_q[1] && hw_ctrl_wr && clear_thermal_latch && sns_s2_q.cooled[1]
       && !sns_s2_q.over_temp[1]) |=> !ot_q[1];
  endproperty
  a_ot_clear: assert property (p_ot_clear) else $error("latch not cleared");

  // dynamic shutdown and fault flag checks
  property p_dyn_stage;
    @(posedge clk) disable iff (!rst_n)
      (sns_s2_q.dyn_shut != '0) |=> ((stage_q & $past(sns_s2_q.dyn_shut)) == '0);
  endproperty
  a_dyn_stage: assert property (p_dyn_stage) else $error("dyn stage on");
  property p_dyn_off;
    @(posedge clk) disable iff (!rst_n)
      (sns_s2_q.dyn_shut != '0)
        |=> ((flag_q & $past(sns_s2_q.dyn_shut)) == $past(sns_s2_q.dyn_shut));
  endproperty
  a_dyn_off: assert property (p_dyn_off) else $error("dyn shutdown fail");
  property p_rd_clear;
    @(posedge clk) disable iff (!rst_n)
      fault_rd |=> ((flag_q & ~$past(sns_s2_q.dyn_shut)) == '0);
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read clear fail");
  property p_flag_reset;
    @(posedge clk) disable iff (!rst_n)
      (fault_rd && (sns_s2_q.dyn_shut != '0))
        |=> ((flag_q & $past(sns_s2_q.dyn_shut)) == $past(sns_s2_q.dyn_shut));
  endproperty
  a_flag_reset: assert property (p_flag_reset) else $error("flag not set again");
  property p_inverse_clear;
    @(posedge clk) disable iff (!rst_n)
      (sns_s2_q.inverse != '0)
        |=> ((flag_q & $past(sns_s2_q.inverse) & ~$past(sns_s2_q.dyn_shut)) == '0);
  endproperty
  a_inverse_clear: assert property (p_inverse_clear) else $error("inverse fail");

  // drive gating checks
  property p_stage_gate;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> ((stage_q & ($past(ot_q) | $past(sns_s2_q.over_temp)
                 | $past(sns_s2_q.dyn_shut))) == '0);
  endproperty
  a_stage_gate: assert property (p_stage_gate) else $error("gated stage on");
  property p_gnd_loss;
    @(posedge clk) disable iff (!rst_n) !gnd_s2_q |=> (stage_q == '0);
  endproperty
  a_gnd_loss: assert property (p_gnd_loss) else $error("ground loss on");
endmodule
`default_nettype wire

// ===== testbench/occ_host.sv
`timescale 1ns/100ps
`default_nettype none
module occ_host (
  // clock
  input  wire logic  clk,
  // register strobes
  output logic       sw_wr,
  output logic       cfg_wr,
  output logic       hw_ctrl_wr,
  output logic       fault_rd,
  output logic       clr_latch,
  output logic [5:0] wd
);
  // idle strobes from time zero
  initial {sw_wr, cfg_wr, hw_ctrl_wr, fault_rd, clr_latch, wd} = '0;
  // one strobe for one edge: 0 switch, 1 config, 2 clear, 3 flag read
  task automatic op(input int k, input logic [5:0] d);
    @(posedge clk) #1;
    wd = d & 6'h1f;
    clr_latch = d[0];
    {fault_rd, hw_ctrl_wr, cfg_wr, sw_wr} = 4'(1 << k);
    @(posedge clk) #1;
    {fault_rd, hw_ctrl_wr, cfg_wr, sw_wr} = 4'h0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/occ_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module occ_top_tb_top import occ_pkg::*; ;
  logic clk = 0, rst_n = 0, gnd_ok = 1, sw_wr, cfg_wr, hw_ctrl_wr, fault_rd, clr_latch, spare;
  logic [5:0] wd, sw_rdata;
  logic [4:0] pin = '0, flag, lat, stg;
  logic [3:0] cfg_rdata;
  logic [2:0] lamp;
  occ_sense_s sense = '0;
  int errors = 0, n_checks = 0, cyc = 0;
  occ_host i_occ_host (.clk(clk), .sw_wr(sw_wr), .cfg_wr(cfg_wr), .hw_ctrl_wr(hw_ctrl_wr),
    .fault_rd(fault_rd), .clr_latch(clr_latch), .wd(wd));
  occ_top i_occ_top (.clk(clk), .rst_n(rst_n), .sw_wr(sw_wr), .sw_wdata(wd),
    .cfg_wr(cfg_wr), .cfg_wdata(wd[3:0]), .hw_ctrl_wr(hw_ctrl_wr),
    .clear_thermal_latch(clr_latch),
    .fault_rd(fault_rd), .channel_input_pin(pin), .sense(sense), .gnd_ok(gnd_ok),
    .sw_rdata(sw_rdata), .cfg_rdata(cfg_rdata), .fault_flag(flag), .ot_latch(lat),
    .stage_on(stg), .lamp_diode_mode_bit(lamp), .spare_bias(spare));
  // clock and cycle ceiling
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      final_report();
    end
  end
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic w(input int n = 4);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_combine;
    i_occ_host.op(0, 6'h35);
    w();
    chk(sw_rdata, 6'h15);
    chk(6'(spare), 6'h00);
    chk(6'(stg), 6'h15);
    pin = 5'h0a;
    w();
    chk(6'(stg), 6'h1f);
    i_occ_host.op(1, 6'h0d);
    w();
    chk(6'(cfg_rdata), 6'h0d);
    chk(6'(lamp), 6'h05);
    chk(6'(stg), 6'h00);
    pin = 5'h17;
    w();
    chk(6'(stg), 6'h15);
    i_occ_host.op(1, 6'h00);
    i_occ_host.op(0, 6'h1f);
    pin = 5'h00;
    w();
    chk(6'(stg), 6'h1f);
  endtask
  task automatic t_thermal;
    sense.over_temp = 5'h0a;
    w();
    chk(6'(lat), 6'h0a);
    chk(6'(stg), 6'h15);
    sense.over_temp = 5'h00;
    i_occ_host.op(2, 6'h01);
    w();
    chk(6'(lat), 6'h0a);
    sense.cooled = 5'h1f;
    w();
    chk(6'(stg), 6'h15);
    i_occ_host.op(2, 6'h01);
    w();
    chk(6'(lat), 6'h00);
    chk(6'(stg), 6'h1f);
  endtask
  task automatic t_dyn;
    sense.dyn_shut = 5'h04;
    w();
    chk(6'(stg), 6'h1b);
    chk(6'(flag), 6'h04);
    i_occ_host.op(3, 6'h00);
    w();
    chk(6'(flag), 6'h04);
    sense.dyn_shut = 5'h00;
    w();
    i_occ_host.op(3, 6'h00);
    w();
    chk(6'(flag), 6'h00);
    sense.dyn_shut = 5'h04;
    w();
    chk(6'(flag), 6'h04);
    sense.dyn_shut = 5'h00;
    sense.inverse = 5'h04;
    w();
    chk(6'(flag), 6'h00);
    sense.inverse = 5'h00;
    gnd_ok = 0;
    w();
    chk(6'(stg), 6'h00);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    w(3);
    rst_n = 1;
    w(1);
    chk(sw_rdata, 6'h00);
    chk(6'(stg), 6'h00);
    t_combine();
    t_thermal();
    t_dyn();
    final_report();
  end
endmodule
`default_nettype wire
